/* File: rtl/blc_consts.svh */
// Constants of the bridge limit checker.
`ifndef BLC_CONSTS_SVH
`define BLC_CONSTS_SVH
`define BLC_NUM_CH 48
`define BLC_CH_PER_BOARD 16
`define BLC_NUM_BOARDS 3
`define BLC_MAX_FLAG_POS 16
`define BLC_OFF_CTRL 8'h00
`define BLC_OFF_CAL_MODE 8'h01
`define BLC_OFF_CAL_VSEL 8'h02
`define BLC_OFF_IRQ_STATUS 8'h03
`define BLC_OFF_IRQ_MASK 8'h04
`define BLC_OFF_ACTIVE_LO 8'h05
`define BLC_OFF_ACTIVE_HI 8'h06
`define BLC_OFF_RESULT 8'h08
`define BLC_OFF_MIN_BASE 2'h1
`define BLC_OFF_MAX_BASE 2'h2
`define BLC_CTRL_EN 0
`define BLC_CTRL_FAST 1
`define BLC_IRQ_PAGE 0
`define BLC_IRQ_LIMIT 1
`define BLC_NEG_INF 32'h80000000
`define BLC_POS_INF 32'h7fffffff
`define BLC_CAL_VOLTAGE_ZERO 5'h00
`define BLC_CAL_VSEL_MAX 8'h12
`endif

/* File: rtl/blc_pkg.sv */
// Types of the bridge limit checker.
package blc_pkg;
   typedef enum logic [1:0] {
      cal_output_off = 2'h0,
      cal_output_on = 2'h1,
      cal_output_shorted = 2'h2,
      cal_output_reference = 2'h3
   } blc_cal_mode_t;

   typedef struct packed {
      logic en;
      logic fast;
      blc_cal_mode_t cal_mode;
      logic [4:0] vsel;
      logic [1:0] irq_st;
      logic [1:0] irq_mask;
      logic irq;
      logic [47:0] act;
      logic [47:0][31:0] lim_min;
      logic [47:0][31:0] lim_max;
      logic [47:0] acc_min;
      logic [47:0] acc_max;
      logic [2:0][31:0] result;
      logic res_valid;
      logic ack;
      logic [31:0] rdat;
   } blc_state_t;
endpackage

/* File: rtl/blc_top.sv */
// Bridge limit checker with calibration selectors and a Wishbone register slave.
`timescale 1ns/10ps
`include "blc_consts.svh"
module blc_top
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic SMP_VALID,
   input wire logic [5:0] SMP_CHAN,
   input wire logic [31:0] SMP_DATA,
   input wire logic PAGE_END,
   output logic [31:0] RESULT_B0,
   output logic [31:0] RESULT_B1,
   output logic [31:0] RESULT_B2,
   output logic RESULT_VALID,
   output logic IRQ,
   output logic [1:0] CAL_MODE,
   output logic [4:0] CAL_VSEL
);

   blc_pkg::blc_state_t st;
   blc_pkg::blc_state_t next_st;
   logic [47:0] cur_min;
   logic [47:0] cur_max;
   logic [47:0] page_min;
   logic [47:0] page_max;
   logic [2:0][31:0] board_word;
   logic req;
   logic [7:0] widx;

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Merges write data into a register under the byte enables.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Tells whether a word index falls in a limit bank.
   function automatic logic in_bank(input logic [7:0] idx, input logic [1:0] bank);
      return (idx[7:6] == bank) && (idx[5:0] < 6'(`BLC_NUM_CH));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Sample comparison against the stored limits.

   assign req = WB_CYC_I && WB_STB_I && !st.ack;
   assign widx = WB_ADR_I[9:2];

   always_comb
   begin
      cur_min = '0;
      cur_max = '0;
      if (SMP_VALID && (SMP_CHAN < 6'(`BLC_NUM_CH)))
      begin
         cur_min[SMP_CHAN] = $signed(SMP_DATA) < $signed(st.lim_min[SMP_CHAN]);
         cur_max[SMP_CHAN] = $signed(SMP_DATA) > $signed(st.lim_max[SMP_CHAN]);
      end
   end

   assign page_min = st.acc_min | cur_min;
   assign page_max = st.acc_max | cur_max;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-board packing of the result word.

   generate
      for (genvar b = 0; b < `BLC_NUM_BOARDS; b++)
      begin : g_board
         always_comb
         begin
            board_word[b] = '0;
            if (st.en && !st.fast)
            begin
               board_word[b][`BLC_MAX_FLAG_POS +: 16] = page_max[b*16 +: 16] & st.act[b*16 +: 16];
               board_word[b][15:0] = page_min[b*16 +: 16] & st.act[b*16 +: 16];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb
   begin
      logic [1:0] clr;
      logic [1:0] set;
      logic [31:0] act_hi;
      clr = '0;
      set = '0;
      act_hi = '0;
      next_st = st;
      next_st.ack = 1'b0;
      next_st.res_valid = 1'b0;
      next_st.acc_min = page_min;
      next_st.acc_max = page_max;
      if (PAGE_END)
      begin
         next_st.result = board_word;
         next_st.res_valid = 1'b1;
         next_st.acc_min = '0;
         next_st.acc_max = '0;
         set[`BLC_IRQ_PAGE] = 1'b1;
         set[`BLC_IRQ_LIMIT] = |board_word;
      end
      if (req)
      begin
         next_st.ack = 1'b1;
         next_st.rdat = '0;
         if (WB_WE_I)
         begin
            if (in_bank(widx, `BLC_OFF_MIN_BASE))
            begin
               next_st.lim_min[widx[5:0]] = merge(st.lim_min[widx[5:0]], WB_DAT_I, WB_SEL_I);
            end
            if (in_bank(widx, `BLC_OFF_MAX_BASE))
            begin
               next_st.lim_max[widx[5:0]] = merge(st.lim_max[widx[5:0]], WB_DAT_I, WB_SEL_I);
            end
            if (WB_SEL_I[0])
            begin
               unique case (widx)
                  `BLC_OFF_CTRL:
                  begin
                     next_st.en = WB_DAT_I[`BLC_CTRL_EN];
                     next_st.fast = WB_DAT_I[`BLC_CTRL_FAST];
                  end
                  `BLC_OFF_CAL_MODE: next_st.cal_mode = blc_pkg::blc_cal_mode_t'(WB_DAT_I[1:0]);
                  `BLC_OFF_CAL_VSEL:
                  begin
                     if (WB_DAT_I[7:0] <= `BLC_CAL_VSEL_MAX)
                     begin
                        next_st.vsel = WB_DAT_I[4:0];
                     end
                  end
                  `BLC_OFF_IRQ_STATUS: clr = WB_DAT_I[1:0];
                  `BLC_OFF_IRQ_MASK: next_st.irq_mask = WB_DAT_I[1:0];
                  default:
                  begin
                  end
               endcase
            end
            if (widx == `BLC_OFF_ACTIVE_LO)
            begin
               next_st.act[31:0] = merge(st.act[31:0], WB_DAT_I, WB_SEL_I);
            end
            if (widx == `BLC_OFF_ACTIVE_HI)
            begin
               act_hi = merge({16'h0000, st.act[47:32]}, WB_DAT_I, WB_SEL_I);
               next_st.act[47:32] = act_hi[15:0];
            end
         end
         else
         begin
            if (in_bank(widx, `BLC_OFF_MIN_BASE))
            begin
               next_st.rdat = st.lim_min[widx[5:0]];
            end
            if (in_bank(widx, `BLC_OFF_MAX_BASE))
            begin
               next_st.rdat = st.lim_max[widx[5:0]];
            end
            unique case (widx)
               `BLC_OFF_CTRL: next_st.rdat = {30'h00000000, st.fast, st.en};
               `BLC_OFF_CAL_MODE: next_st.rdat = {30'h00000000, st.cal_mode};
               `BLC_OFF_CAL_VSEL: next_st.rdat = {27'h0000000, st.vsel};
               `BLC_OFF_IRQ_STATUS: next_st.rdat = {30'h00000000, st.irq_st};
               `BLC_OFF_IRQ_MASK: next_st.rdat = {30'h00000000, st.irq_mask};
               `BLC_OFF_ACTIVE_LO: next_st.rdat = st.act[31:0];
               `BLC_OFF_ACTIVE_HI: next_st.rdat = {16'h0000, st.act[47:32]};
               `BLC_OFF_RESULT: next_st.rdat = st.result[0];
               `BLC_OFF_RESULT + 8'h01: next_st.rdat = st.result[1];
               `BLC_OFF_RESULT + 8'h02: next_st.rdat = st.result[2];
               default:
               begin
               end
            endcase
         end
      end
      next_st.irq_st = (st.irq_st & ~clr) | set;
      next_st.irq = |(next_st.irq_st & next_st.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         st <= '0;
         st.lim_min <= {`BLC_NUM_CH{`BLC_NEG_INF}};
         st.lim_max <= {`BLC_NUM_CH{`BLC_POS_INF}};
         st.cal_mode <= blc_pkg::cal_output_off;
         st.vsel <= `BLC_CAL_VOLTAGE_ZERO;
      end
      else if (CE)
      begin
         st <= next_st;
      end
   end

   assign WB_DAT_O = st.rdat;
   assign WB_ACK_O = st.ack;
   assign RESULT_B0 = st.result[0];
   assign RESULT_B1 = st.result[1];
   assign RESULT_B2 = st.result[2];
   assign RESULT_VALID = st.res_valid;
   assign IRQ = st.irq;
   assign CAL_MODE = st.cal_mode;
   assign CAL_VSEL = st.vsel;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   property p_limits_reset;
      $past(!RST_N) |-> st.lim_min[5] == `BLC_NEG_INF && st.lim_max[40] == `BLC_POS_INF;
   endproperty
   a_limits_reset: assert property (p_limits_reset) else $error("Limits not infinite after reset.");

   property p_enable_reset;
      $past(!RST_N) |-> !st.en && st.vsel == 5'h00;
   endproperty
   a_enable_reset: assert property (p_enable_reset) else $error("Enable or selector wrong after reset.");

   property p_max_flag;
      CE && PAGE_END && SMP_VALID && SMP_CHAN == 6'h02 && st.en && !st.fast && st.act[2]
         && $signed(SMP_DATA) > $signed(st.lim_max[2]) |=> RESULT_VALID && RESULT_B0[18];
   endproperty
   a_max_flag: assert property (p_max_flag) else $error("Maximum flag of channel 2 missing.");

   property p_min_flag;
      CE && PAGE_END && SMP_VALID && SMP_CHAN == 6'h11 && st.en && !st.fast && st.act[17] && !st.acc_max[17]
         && $signed(SMP_DATA) < $signed(st.lim_min[17]) && $signed(SMP_DATA) <= $signed(st.lim_max[17])
         |=> RESULT_B1[1] && !RESULT_B1[17];
   endproperty
   a_min_flag: assert property (p_min_flag) else $error("Minimum flag of channel 17 misplaced.");

   property p_fast_zero;
      CE && PAGE_END && st.fast |=> RESULT_VALID && RESULT_B0 == '0 && RESULT_B2 == '0;
   endproperty
   a_fast_zero: assert property (p_fast_zero) else $error("Result not zero at high rate.");

   property p_disabled_zero;
      CE && PAGE_END && !st.en |=> RESULT_VALID && RESULT_B1 == '0 && RESULT_B2 == '0;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("Result not zero while disabled.");

   property p_inactive_zero;
      RESULT_VALID |-> (RESULT_B0 & ~{2{$past(st.act[15:0])}}) == '0;
   endproperty
   a_inactive_zero: assert property (p_inactive_zero) else $error("Inactive channel flag set.");

   property p_fresh_page;
      CE && PAGE_END |=> st.acc_min == '0 && st.acc_max == '0;
   endproperty
   a_fresh_page: assert property (p_fresh_page) else $error("Flags carried across pages.");

   property p_vsel_range;
      st.vsel <= 5'h12;
   endproperty
   a_vsel_range: assert property (p_vsel_range) else $error("Voltage selector out of range.");

   property p_cal_mode;
      CE && req && WB_WE_I && WB_SEL_I[0] && widx == `BLC_OFF_CAL_MODE |=> CAL_MODE == $past(WB_DAT_I[1:0]);
   endproperty
   a_cal_mode: assert property (p_cal_mode) else $error("Calibration mode not taken.");

   property p_ack;
      CE && req |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("Bus answer not one cycle wide.");

   c_flag_page: cover property (RESULT_VALID && RESULT_B0 != '0);
   c_disabled_page: cover property (CE && PAGE_END && !st.en);
   c_fast_page: cover property (CE && PAGE_END && st.en && st.fast);
   c_irq: cover property ($rose(IRQ));
endmodule

/* File: tb/tb_top.sv */
// Self-checking testbench of the bridge limit checker.
`timescale 1ns/10ps
module tb_top;
   logic CLK, RST_N, CE, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, SMP_VALID, PAGE_END, RESULT_VALID, IRQ;
   logic [9:0] WB_ADR_I;
   logic [3:0] WB_SEL_I;
   logic [31:0] WB_DAT_I, WB_DAT_O, SMP_DATA, RESULT_B0, RESULT_B1, RESULT_B2, rd;
   logic [5:0] SMP_CHAN;
   logic [1:0] CAL_MODE;
   logic [4:0] CAL_VSEL;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   blc_top blc_top_inst (.CLK(CLK), .RST_N(RST_N), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O), .SMP_VALID(SMP_VALID), .SMP_CHAN(SMP_CHAN), .SMP_DATA(SMP_DATA), .PAGE_END(PAGE_END),
      .RESULT_B0(RESULT_B0), .RESULT_B1(RESULT_B1), .RESULT_B2(RESULT_B2), .RESULT_VALID(RESULT_VALID),
      .IRQ(IRQ), .CAL_MODE(CAL_MODE), .CAL_VSEL(CAL_VSEL));
   ////////////////////////////////////////////////////////////////
   // Clock and timeout.
   initial
   begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////
   // Shared tasks.
   task automatic print_verdict();
      $display("Mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic Wishbone cycle; read data is taken at the edge that sees ack.
   task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      WB_SEL_I <= 4'hf;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (WB_ACK_O !== 1'b1 && n < 50);
      if (n >= 50)
         chk("bus ack", 32'h1, 32'h0);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask
   task automatic smp(input logic [5:0] ch, input logic [31:0] d);
      @(posedge CLK);
      SMP_VALID <= 1'b1;
      SMP_CHAN <= ch;
      SMP_DATA <= d;
      @(posedge CLK);
      SMP_VALID <= 1'b0;
   endtask
   // Closes a page and checks the three words in the cycle after.
   task automatic page(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
      @(posedge CLK);
      PAGE_END <= 1'b1;
      @(posedge CLK);
      PAGE_END <= 1'b0;
      #1;
      chk("result valid", 32'h1, {31'h0, RESULT_VALID});
      chk("board 0 word", e0, RESULT_B0);
      chk("board 1 word", e1, RESULT_B1);
      chk("board 2 word", e2, RESULT_B2);
      @(posedge CLK);
      #1;
      chk("result valid drop", 32'h0, {31'h0, RESULT_VALID});
   endtask
   ////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset();
      chk("cal mode", 32'h0, {30'h0, CAL_MODE});
      chk("cal vsel", 32'h0, {27'h0, CAL_VSEL});
      chk("irq", 32'h0, {31'h0, IRQ});
      wb(1'b0, 10'h100, 32'h0);
      chk("min ch0", 32'h80000000, rd);
      wb(1'b0, 10'h2bc, 32'h0);
      chk("max ch47", 32'h7fffffff, rd);
      wb(1'b0, 10'h000, 32'h0);
      chk("ctrl", 32'h0, rd);
      wb(1'b0, 10'h3fc, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask
   task automatic t_cal();
      for (int m = 0; m < 4; m++)
      begin
         wb(1'b1, 10'h004, 32'(m));
         chk("cal mode", 32'(m), {30'h0, CAL_MODE});
      end
      for (int v = 0; v <= 18; v++)
      begin
         wb(1'b1, 10'h008, 32'(v));
         chk("cal vsel", 32'(v), {27'h0, CAL_VSEL});
      end
      wb(1'b1, 10'h008, 32'h13);
      chk("cal vsel refused", 32'h12, {27'h0, CAL_VSEL});
   endtask
   task automatic t_limits();
      wb(1'b1, 10'h014, 32'hffffffff);
      wb(1'b1, 10'h018, 32'h0000ffff);
      wb(1'b1, 10'h010, 32'h2);
      wb(1'b1, 10'h000, 32'h1);
      smp(6'h00, 32'h7fffffff);
      smp(6'h01, 32'h80000000);
      page(32'h0, 32'h0, 32'h0);
      chk("irq masked", 32'h0, {31'h0, IRQ});
      wb(1'b1, 10'h208, 32'h64);
      wb(1'b1, 10'h108, 32'hffffff9c);
      wb(1'b1, 10'h1bc, 32'h0);
      wb(1'b1, 10'h248, 32'h5);
      smp(6'h02, 32'h65);
      smp(6'h2f, 32'hffffffff);
      smp(6'h12, 32'h5);
      smp(6'h32, 32'h80000000);
      page(32'h00040000, 32'h0, 32'h00008000);
      chk("irq", 32'h1, {31'h0, IRQ});
      smp(6'h02, 32'hffffff9b);
      smp(6'h12, 32'h6);
      page(32'h00000004, 32'h00040000, 32'h0);
      wb(1'b0, 10'h00c, 32'h0);
      chk("status", 32'h3, rd);
      wb(1'b1, 10'h00c, 32'h3);
      chk("irq cleared", 32'h0, {31'h0, IRQ});
   endtask
   task automatic t_inactive();
      wb(1'b1, 10'h014, 32'hfffffffb);
      smp(6'h02, 32'h65);
      smp(6'h12, 32'h6);
      page(32'h0, 32'h00040000, 32'h0);
      wb(1'b1, 10'h014, 32'hffffffff);
   endtask
   task automatic t_off();
      wb(1'b1, 10'h000, 32'h3);
      smp(6'h02, 32'h65);
      page(32'h0, 32'h0, 32'h0);
      wb(1'b1, 10'h000, 32'h0);
      smp(6'h02, 32'h65);
      page(32'h0, 32'h0, 32'h0);
      wb(1'b1, 10'h010, 32'h0);
      wb(1'b1, 10'h000, 32'h1);
      smp(6'h02, 32'h65);
      page(32'h00040000, 32'h0, 32'h0);
      chk("irq masked off", 32'h0, {31'h0, IRQ});
   endtask
   // Samples that close their own pages, then a page end while the clock enable is low.
   task automatic t_same_cycle();
      wb(1'b1, 10'h144, 32'h0);
      wb(1'b1, 10'h00c, 32'h3);
      wb(1'b1, 10'h010, 32'h2);
      chk("irq before", 32'h0, {31'h0, IRQ});
      @(posedge CLK);
      SMP_VALID <= 1'b1;
      SMP_CHAN <= 6'h02;
      SMP_DATA <= 32'h65;
      PAGE_END <= 1'b1;
      @(posedge CLK);
      SMP_CHAN <= 6'h11;
      SMP_DATA <= 32'hffffffff;
      #1;
      chk("same cycle valid", 32'h1, {31'h0, RESULT_VALID});
      chk("same cycle board 0", 32'h00040000, RESULT_B0);
      @(posedge CLK);
      SMP_VALID <= 1'b0;
      PAGE_END <= 1'b0;
      #1;
      chk("same cycle board 1", 32'h00000002, RESULT_B1);
      chk("same cycle board 0 fresh", 32'h0, RESULT_B0);
      chk("same cycle irq", 32'h1, {31'h0, IRQ});
      @(posedge CLK);
      CE <= 1'b0;
      SMP_VALID <= 1'b1;
      SMP_CHAN <= 6'h12;
      SMP_DATA <= 32'h6;
      PAGE_END <= 1'b1;
      repeat (2) @(posedge CLK);
      CE <= 1'b1;
      SMP_VALID <= 1'b0;
      PAGE_END <= 1'b0;
      #1;
      chk("frozen valid", 32'h0, {31'h0, RESULT_VALID});
      chk("frozen board 1", 32'h00000002, RESULT_B1);
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      RST_N = 1'b0;
      CE = 1'b1;
      WB_CYC_I = 1'b0;
      WB_STB_I = 1'b0;
      WB_WE_I = 1'b0;
      WB_ADR_I = 10'h0;
      WB_SEL_I = 4'h0;
      WB_DAT_I = 32'h0;
      SMP_VALID = 1'b0;
      SMP_CHAN = 6'h0;
      SMP_DATA = 32'h0;
      PAGE_END = 1'b0;
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      t_reset();
      t_cal();
      t_limits();
      t_inactive();
      t_off();
      t_same_cycle();
      print_verdict();
   end
endmodule
